// [logic/prt_detector.sv]
// one setting set: pulse width detector and runt detector on selectable channels
`timescale 1ns/1ps
`default_nettype none
module prt_detector #(
    parameter int WMAX_CYC = prt_pkg::WIDTH_MAX_CYC
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire prt_pkg::prt_ch_flags_s ch_flags,
    input wire prt_pkg::prt_set_cfg_s cfg,
    output logic width_fire,
    output logic runt_fire,
    output logic needs_long
);
    localparam logic [prt_pkg::CNT_W-1:0] WMAX_CNT = prt_pkg::CNT_W'(WMAX_CYC);

    function automatic logic pick(input logic [3:0] f, input logic [2:0] idx);
        logic [2:0] off;
        off = idx - prt_pkg::CH_FIRST;
        pick = 1'b0;
        if (idx >= prt_pkg::CH_FIRST && idx <= prt_pkg::CH_LAST) begin
            pick = f[off[1:0]];
        end
    endfunction : pick

    logic [prt_pkg::CNT_W-1:0] wlim;
    logic [prt_pkg::CNT_W-1:0] rmin;
    logic [prt_pkg::CNT_W-1:0] w_cnt_reg;
    logic [prt_pkg::CNT_W-1:0] r_cnt_reg;
    logic saw_inner_reg;
    logic width_fire_reg;
    logic runt_fire_reg;
    logic w_now;
    logic w_end;
    logic timeout_mode;
    logic r_outer;
    logic r_inner;
    logic r_end;

    // limits clamped into the programmable range
    always_comb begin
        wlim = cfg.width_limit;
        if (wlim < prt_pkg::WIDTH_MIN_CNT) begin
            wlim = prt_pkg::WIDTH_MIN_CNT;
        end else if (wlim > WMAX_CNT) begin
            wlim = WMAX_CNT;
        end
        rmin = cfg.runt_min;
        if (rmin < prt_pkg::RUNT_MIN_CNT) begin
            rmin = prt_pkg::RUNT_MIN_CNT;
        end else if (rmin > prt_pkg::RUNT_MAX_CNT) begin
            rmin = prt_pkg::RUNT_MAX_CNT;
        end
    end

    // positive measures the high part, negative the low part; a bad source index stays idle in both
    assign w_now = pick('1, cfg.width_source)
                   & (cfg.width_polarity_pos ~^ pick(ch_flags.level, cfg.width_source));
    assign w_end = ~w_now && (w_cnt_reg != prt_pkg::CNT_ZERO);
    assign timeout_mode = cfg.wider_than & cfg.trigger_point_select;
    assign needs_long = wlim > prt_pkg::LONG_TIMER_CNT;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            w_cnt_reg <= prt_pkg::CNT_ZERO;
        end else if (!w_now) begin
            w_cnt_reg <= prt_pkg::CNT_ZERO;
        end else if (w_cnt_reg != prt_pkg::CNT_SAT) begin
            w_cnt_reg <= w_cnt_reg + prt_pkg::CNT_ONE;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            width_fire_reg <= 1'b0;
        end else if (timeout_mode) begin
            // count equals limit while still present: width now exceeds it
            width_fire_reg <= w_now && (w_cnt_reg == wlim);
        end else if (cfg.wider_than) begin
            width_fire_reg <= w_end && (w_cnt_reg > wlim);
        end else begin
            width_fire_reg <= w_end && (w_cnt_reg < wlim);
        end
    end

    // positive runt rises past low but never reaches high; negative mirrors it
    assign r_outer = cfg.runt_polarity_pos ? pick(ch_flags.above_low, cfg.runt_source)
                                           : ~pick(ch_flags.above_high, cfg.runt_source);
    assign r_inner = cfg.runt_polarity_pos ? pick(ch_flags.above_high, cfg.runt_source)
                                           : ~pick(ch_flags.above_low, cfg.runt_source);
    assign r_end = ~r_outer && (r_cnt_reg != prt_pkg::CNT_ZERO);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            r_cnt_reg <= prt_pkg::CNT_ZERO;
            saw_inner_reg <= 1'b0;
        end else if (!r_outer) begin
            r_cnt_reg <= prt_pkg::CNT_ZERO;
            saw_inner_reg <= 1'b0;
        end else begin
            if (r_cnt_reg != prt_pkg::CNT_SAT) begin
                r_cnt_reg <= r_cnt_reg + prt_pkg::CNT_ONE;
            end
            saw_inner_reg <= saw_inner_reg | r_inner;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            runt_fire_reg <= 1'b0;
        end else begin
            runt_fire_reg <= r_end && !saw_inner_reg && (!cfg.runt_qualified || r_cnt_reg > rmin);
        end
    end

    assign width_fire = width_fire_reg;
    assign runt_fire = runt_fire_reg;
endmodule : prt_detector
`default_nettype wire

// [logic/prt_pkg.sv]
// package: constants, types and timing for the pulse/runt/sequence trigger qualifier
`default_nettype none
package prt_pkg;
    localparam int CLK_HZ = 50_000_000;
    localparam int CLK_PERIOD_PS = 20_000;
    localparam int CNT_W = 29;
    localparam int WIDTH_MIN_PS = 250;
    localparam int WIDTH_MAX_S = 10;
    localparam int RUNT_MIN_PS = 250;
    localparam int RUNT_MAX_PS = 30_000;
    localparam int LONG_TIMER_PS = 30_000;
    // least times round up, longest times round down, never below one cycle
    localparam int WIDTH_MIN_CYC = (WIDTH_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WIDTH_MAX_CYC = WIDTH_MAX_S * CLK_HZ;
    localparam int RUNT_MIN_CYC = (RUNT_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int RUNT_MAX_RAW = RUNT_MAX_PS / CLK_PERIOD_PS;
    localparam int RUNT_MAX_CYC = (RUNT_MAX_RAW < 1) ? 1 : RUNT_MAX_RAW;
    localparam int LONG_RAW = LONG_TIMER_PS / CLK_PERIOD_PS;
    localparam int LONG_TIMER_CYC = (LONG_RAW < 1) ? 1 : LONG_RAW;
    localparam logic [CNT_W-1:0] WIDTH_MIN_CNT = CNT_W'(WIDTH_MIN_CYC);
    localparam logic [CNT_W-1:0] RUNT_MIN_CNT = CNT_W'(RUNT_MIN_CYC);
    localparam logic [CNT_W-1:0] RUNT_MAX_CNT = CNT_W'(RUNT_MAX_CYC);
    localparam logic [CNT_W-1:0] LONG_TIMER_CNT = CNT_W'(LONG_TIMER_CYC);
    localparam logic [CNT_W-1:0] CNT_ZERO = {CNT_W{1'b0}};
    localparam logic [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};
    localparam logic [CNT_W-1:0] CNT_SAT = {CNT_W{1'b1}};
    localparam logic [2:0] CH_FIRST = 3'h1;
    localparam logic [2:0] CH_LAST = 3'h4;
    localparam int NUM_SETS = 2;
    localparam int TERM_W = 9;
    localparam int WIDTH_BIT = 2;
    localparam int RUNT_BIT = 3;

    typedef enum logic [TERM_W-1:0] {
        TERM_EDGE = 9'h001,
        TERM_GLITCH = 9'h002,
        TERM_WIDTH = 9'h004,
        TERM_RUNT = 9'h008,
        TERM_SETUP_HOLD = 9'h010,
        TERM_STATE = 9'h020,
        TERM_TIMEOUT = 9'h040,
        TERM_TRANSITION = 9'h080,
        TERM_WINDOW = 9'h100
    } prt_term_e;

    typedef enum logic [2:0] {
        SEQ_SEEK_FIRST = 3'h1,
        SEQ_SETTLE = 3'h2,
        SEQ_SEEK_SECOND = 3'h4
    } prt_seq_e;

    typedef struct packed {
        logic [3:0] level;
        logic [3:0] above_low;
        logic [3:0] above_high;
    } prt_ch_flags_s;

    typedef struct packed {
        logic width_polarity_pos;
        logic wider_than;
        logic trigger_point_select;
        logic [2:0] width_source;
        logic [CNT_W-1:0] width_limit;
        logic runt_polarity_pos;
        logic runt_qualified;
        logic [2:0] runt_source;
        logic [CNT_W-1:0] runt_min;
    } prt_set_cfg_s;
endpackage : prt_pkg
`default_nettype wire

// [logic/prt_trigger.sv]
// top: two setting sets, shared resource arbitration and the two-term sequencer
// Summary of operation
// - width detector fires wider or narrower than limit
// - negative polarity ends on rising edge crossing
// - positive polarity ends on falling edge crossing
// - width input channel chosen by index 1-4
// - fire at pulse end or limit elapsed
// - elapsed-time point only in wider-than mode
// - width limit spans 250 ps to 10 s; the code clamps its low end to one 20 ns cycle
// - set one feeds first term, two second
// - runt polarity picks pulse direction
// - qualification readback is one or zero
// - qualified runt needs width over minimum
// - runt input channel chosen by index 1-4
// - first term picks one of nine types
// - second term picks nine types, final trigger
// - duration range shared, one term only
// - one long timer, one term only
// - device grants shared resources itself
// - reset timeout returns to seeking first term
// - delay waits before seeking second term
`timescale 1ns/1ps
`default_nettype none
module prt_trigger #(
    parameter int WIDTH_MAX_CYC = prt_pkg::WIDTH_MAX_CYC
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire prt_pkg::prt_ch_flags_s ch_flags,
    input wire prt_pkg::prt_set_cfg_s set_cfg_one,
    input wire prt_pkg::prt_set_cfg_s set_cfg_two,
    input wire prt_pkg::prt_term_e first_term,
    input wire prt_pkg::prt_term_e second_term,
    input wire logic sequence_enable,
    input wire logic [prt_pkg::TERM_W-1:0] ext_fire_one,
    input wire logic [prt_pkg::TERM_W-1:0] ext_fire_two,
    input wire logic ext_long_req_one,
    input wire logic ext_long_req_two,
    input wire logic range_req_one,
    input wire logic range_req_two,
    input wire logic reset_time_enable,
    input wire logic [prt_pkg::CNT_W-1:0] reset_time_cycles,
    input wire logic delay_enable,
    input wire logic [prt_pkg::CNT_W-1:0] delay_cycles,
    output logic trigger_out,
    output logic first_fire_out,
    output logic sequence_armed,
    output logic [prt_pkg::NUM_SETS-1:0] long_timer_grant,
    output logic [prt_pkg::NUM_SETS-1:0] range_grant,
    output logic [prt_pkg::NUM_SETS-1:0] runt_qualified_readback,
    output logic [prt_pkg::NUM_SETS-1:0] trigger_point_readback
);
    // selects the detector output that the chosen term type names
    function automatic logic term_fire(input logic [prt_pkg::TERM_W-1:0] term,
                                       input logic [prt_pkg::TERM_W-1:0] ext,
                                       input logic w,
                                       input logic r);
        logic [prt_pkg::TERM_W-1:0] src;
        src = ext;
        src[prt_pkg::WIDTH_BIT] = w;
        src[prt_pkg::RUNT_BIT] = r;
        term_fire = |(term & src);
    endfunction : term_fire

    prt_pkg::prt_set_cfg_s cfg [prt_pkg::NUM_SETS];
    prt_pkg::prt_term_e term_sel [prt_pkg::NUM_SETS];
    logic [prt_pkg::TERM_W-1:0] ext_fire [prt_pkg::NUM_SETS];
    logic [prt_pkg::NUM_SETS-1:0] width_fire;
    logic [prt_pkg::NUM_SETS-1:0] runt_fire;
    logic [prt_pkg::NUM_SETS-1:0] width_long;
    logic [prt_pkg::NUM_SETS-1:0] ext_long;
    logic [prt_pkg::NUM_SETS-1:0] rng_req_in;
    logic [prt_pkg::NUM_SETS-1:0] long_req;
    logic [prt_pkg::NUM_SETS-1:0] rng_req;
    logic [prt_pkg::NUM_SETS-1:0] raw_fire;
    logic [prt_pkg::NUM_SETS-1:0] term_ok;
    logic [prt_pkg::NUM_SETS-1:0] long_grant_reg;
    logic [prt_pkg::NUM_SETS-1:0] long_grant_next;
    logic [prt_pkg::NUM_SETS-1:0] range_grant_reg;
    logic [prt_pkg::NUM_SETS-1:0] range_grant_next;
    logic [prt_pkg::NUM_SETS-1:0] qual_rb_reg;
    logic [prt_pkg::NUM_SETS-1:0] tp_rb_reg;
    logic fire_first;
    logic fire_second;
    prt_pkg::prt_seq_e state_reg;
    prt_pkg::prt_seq_e state_next;
    logic [prt_pkg::CNT_W-1:0] timer_reg;
    logic [prt_pkg::CNT_W-1:0] timer_next;
    logic trigger_reg;
    logic trigger_next;
    logic first_fire_reg;

    assign cfg[0] = set_cfg_one;
    assign cfg[1] = set_cfg_two;
    assign term_sel[0] = first_term;
    assign term_sel[1] = second_term;
    assign ext_fire[0] = ext_fire_one;
    assign ext_fire[1] = ext_fire_two;
    assign ext_long = {ext_long_req_two, ext_long_req_one};
    assign rng_req_in = {range_req_two, range_req_one};

    genvar gi;
    generate
        for (gi = 0; gi < prt_pkg::NUM_SETS; gi++) begin : g_set
            prt_detector #(
                .WMAX_CYC(WIDTH_MAX_CYC)
            ) u_det (
                .sys_clk(sys_clk),
                .reset_n(reset_n),
                .ch_flags(ch_flags),
                .cfg(cfg[gi]),
                .width_fire(width_fire[gi]),
                .runt_fire(runt_fire[gi]),
                .needs_long(width_long[gi])
            );

            // a term asks for the long timer through its own width limit or an outside detector
            assign long_req[gi] = (term_sel[gi] == prt_pkg::TERM_WIDTH) ? width_long[gi]
                                                                      : ext_long[gi];
            assign rng_req[gi] = (term_sel[gi] == prt_pkg::TERM_STATE) & rng_req_in[gi];
            assign raw_fire[gi] = term_fire(term_sel[gi], ext_fire[gi], width_fire[gi], runt_fire[gi]);
            // a term denied a shared resource cannot fire
            assign term_ok[gi] = (~long_req[gi] | long_grant_reg[gi]) & (~rng_req[gi] | range_grant_reg[gi]);

            always_ff @(posedge sys_clk or negedge reset_n) begin
                if (!reset_n) begin
                    qual_rb_reg[gi] <= 1'b0;
                    tp_rb_reg[gi] <= 1'b0;
                end else begin
                    qual_rb_reg[gi] <= cfg[gi].runt_qualified;
                    // narrower-than always reads back as pulse end
                    tp_rb_reg[gi] <= cfg[gi].trigger_point_select & cfg[gi].wider_than;
                end
            end
        end
    endgenerate

    // first term keeps priority; second term gets a resource only once first frees it
    always_comb begin
        long_grant_next[0] = long_req[0];
        long_grant_next[1] = long_req[1] & ~long_req[0];
        range_grant_next[0] = rng_req[0];
        range_grant_next[1] = rng_req[1] & ~rng_req[0];
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            long_grant_reg <= '0;
            range_grant_reg <= '0;
        end else begin
            long_grant_reg <= long_grant_next;
            range_grant_reg <= range_grant_next;
        end
    end

    assign fire_first = raw_fire[0] & term_ok[0];
    assign fire_second = raw_fire[1] & term_ok[1];

    // timer_reg counts cycles spent in the current waiting state, starting at one
    always_comb begin
        state_next = state_reg;
        timer_next = timer_reg;
        trigger_next = 1'b0;
        if (timer_reg != prt_pkg::CNT_SAT) begin
            timer_next = timer_reg + prt_pkg::CNT_ONE;
        end
        case (state_reg)
            prt_pkg::SEQ_SEEK_FIRST: begin
                timer_next = prt_pkg::CNT_ONE;
                if (!sequence_enable) begin
                    trigger_next = fire_first;
                end else if (fire_first && delay_enable) begin
                    state_next = prt_pkg::SEQ_SETTLE;
                end else if (fire_first) begin
                    state_next = prt_pkg::SEQ_SEEK_SECOND;
                end
            end
            prt_pkg::SEQ_SETTLE: begin
                // second term ignored until the delay has run out
                if (!sequence_enable) begin
                    state_next = prt_pkg::SEQ_SEEK_FIRST;
                end else if (timer_reg >= delay_cycles) begin
                    state_next = prt_pkg::SEQ_SEEK_SECOND;
                    timer_next = prt_pkg::CNT_ONE;
                end
            end
            prt_pkg::SEQ_SEEK_SECOND: begin
                if (!sequence_enable) begin
                    state_next = prt_pkg::SEQ_SEEK_FIRST;
                end else if (fire_second) begin
                    // a second-term hit beats a reset timeout in the same cycle
                    trigger_next = 1'b1;
                    state_next = prt_pkg::SEQ_SEEK_FIRST;
                end else if (reset_time_enable && timer_reg >= reset_time_cycles) begin
                    state_next = prt_pkg::SEQ_SEEK_FIRST;
                end
            end
            default: begin
                state_next = prt_pkg::SEQ_SEEK_FIRST;
                timer_next = prt_pkg::CNT_ONE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= prt_pkg::SEQ_SEEK_FIRST;
            timer_reg <= prt_pkg::CNT_ONE;
        end else begin
            state_reg <= state_next;
            timer_reg <= timer_next;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            trigger_reg <= 1'b0;
            first_fire_reg <= 1'b0;
        end else begin
            trigger_reg <= trigger_next;
            first_fire_reg <= fire_first && (state_reg == prt_pkg::SEQ_SEEK_FIRST);
        end
    end

    assign trigger_out = trigger_reg;
    assign first_fire_out = first_fire_reg;
    assign sequence_armed = state_reg == prt_pkg::SEQ_SEEK_SECOND;
    assign long_timer_grant = long_grant_reg;
    assign range_grant = range_grant_reg;
    assign runt_qualified_readback = qual_rb_reg;
    assign trigger_point_readback = tp_rb_reg;
endmodule : prt_trigger
`default_nettype wire

// [verification/prt_checker_model.sv]
// comparator model: four channels, three threshold flags each
`timescale 1ns/1ps
`default_nettype none
module prt_comparator_model (
    input wire logic sys_clk,
    input wire logic [7:0] volt,
    output var prt_pkg::prt_ch_flags_s ch_flags
);
    // volt per channel: 0 below low, 1 between, 2 or 3 above high; flags leave registered
    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < 4; i++) begin
            ch_flags.level[i] <= volt[2*i +: 2] != 2'h0;
            ch_flags.above_low[i] <= volt[2*i +: 2] != 2'h0;
            ch_flags.above_high[i] <= volt[2*i+1];
        end
    end
endmodule : prt_comparator_model
`default_nettype wire

// [verification/prt_trigger_checker.sv]
// assertion checker bound to the trigger qualifier top
`timescale 1ns/1ps
`default_nettype none
module prt_trigger_checker (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire prt_pkg::prt_set_cfg_s set_cfg_one,
    input wire prt_pkg::prt_set_cfg_s set_cfg_two,
    input wire prt_pkg::prt_term_e first_term,
    input wire logic sequence_enable,
    input wire logic delay_enable,
    input wire logic range_req_one,
    input wire logic trigger_out,
    input wire logic first_fire_out,
    input wire logic sequence_armed,
    input wire logic [prt_pkg::NUM_SETS-1:0] long_timer_grant,
    input wire logic [prt_pkg::NUM_SETS-1:0] range_grant,
    input wire logic [prt_pkg::NUM_SETS-1:0] runt_qualified_readback,
    input wire logic [prt_pkg::NUM_SETS-1:0] trigger_point_readback
);
    logic [1:0] tp_w;
    logic [1:0] rq_w;
    assign tp_w = {set_cfg_two.wider_than & set_cfg_two.trigger_point_select,
                   set_cfg_one.wider_than & set_cfg_one.trigger_point_select};
    assign rq_w = {set_cfg_two.runt_qualified, set_cfg_one.runt_qualified};
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);
    trig_single_a: assert property (trigger_out && sequence_enable && $past(sequence_enable) |=> !trigger_out)
        else $error("trigger longer than one cycle");
    first_arms_a: assert property (first_fire_out && sequence_enable && $past(sequence_enable)
        && !$past(delay_enable) |-> sequence_armed) else $error("first term did not arm");
    delay_settle_a: assert property (first_fire_out && sequence_enable && $past(sequence_enable)
        && $past(delay_enable) |-> !sequence_armed) else $error("armed without delay");
    trig_needs_arm_a: assert property (trigger_out && $past(sequence_enable) |-> $past(sequence_armed))
        else $error("trigger while not armed");
    trig_disarm_a: assert property (trigger_out && $past(sequence_enable) |-> !sequence_armed)
        else $error("still armed after trigger");
    long_onehot_a: assert property ($onehot0(long_timer_grant)) else $error("long timer granted twice");
    range_onehot_a: assert property ($onehot0(range_grant)) else $error("range granted twice");
    range_first_a: assert property (range_req_one && first_term == prt_pkg::TERM_STATE |=> range_grant[0])
        else $error("range not granted to first term");
    tp_readback_a: assert property (1'b1 |=> trigger_point_readback == $past(tp_w))
        else $error("trigger point readback wrong");
    rq_readback_a: assert property (1'b1 |=> runt_qualified_readback == $past(rq_w))
        else $error("qualification readback wrong");
endmodule : prt_trigger_checker
bind prt_trigger prt_trigger_checker i_prt_trigger_checker (.sys_clk(sys_clk), .reset_n(reset_n),
    .set_cfg_one(set_cfg_one), .set_cfg_two(set_cfg_two), .first_term(first_term),
    .sequence_enable(sequence_enable), .delay_enable(delay_enable), .range_req_one(range_req_one),
    .trigger_out(trigger_out), .first_fire_out(first_fire_out), .sequence_armed(sequence_armed),
    .long_timer_grant(long_timer_grant), .range_grant(range_grant),
    .runt_qualified_readback(runt_qualified_readback), .trigger_point_readback(trigger_point_readback));
`default_nettype wire

// [verification/tb_prt_trigger.sv]
// self-checking bench for the pulse, runt and sequence trigger qualifier
`timescale 1ns/1ps
`default_nettype none
module tb_prt_trigger;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    prt_pkg::prt_ch_flags_s flags;
    prt_pkg::prt_set_cfg_s cfg1 = '0, cfg2 = '0;
    prt_pkg::prt_term_e ft = prt_pkg::TERM_WIDTH, st = prt_pkg::TERM_RUNT;
    logic seq_en = 1'b0, elr1 = 1'b0, elr2 = 1'b0, rr1 = 1'b0, rr2 = 1'b0, rte = 1'b0, de = 1'b0;
    logic [8:0] ef1 = 9'h000, ef2 = 9'h000;
    logic [28:0] rtc = 29'h4, dc = 29'h6;
    logic [7:0] volt = 8'h00;
    logic trg, ff, armed;
    logic [1:0] ltg, rg, rqr, tpr;
    int miscompares = 0, checks = 0, trg_cnt = 0, base = 0;
    prt_comparator_model i_prt_comparator_model (.sys_clk(sys_clk), .volt(volt), .ch_flags(flags));
    // short width ceiling clamps the width limit to 64 cycles in simulation
    prt_trigger #(.WIDTH_MAX_CYC(64)) i_prt_trigger (.sys_clk(sys_clk), .reset_n(reset_n), .ch_flags(flags),
        .set_cfg_one(cfg1), .set_cfg_two(cfg2), .first_term(ft), .second_term(st), .sequence_enable(seq_en),
        .ext_fire_one(ef1), .ext_fire_two(ef2), .ext_long_req_one(elr1), .ext_long_req_two(elr2),
        .range_req_one(rr1), .range_req_two(rr2), .reset_time_enable(rte), .reset_time_cycles(rtc),
        .delay_enable(de), .delay_cycles(dc), .trigger_out(trg), .first_fire_out(ff), .sequence_armed(armed),
        .long_timer_grant(ltg), .range_grant(rg), .runt_qualified_readback(rqr), .trigger_point_readback(tpr));
    initial forever #10 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (trg === 1'b1) trg_cnt <= trg_cnt + 1;
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : tick
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    task automatic trg_is(input int exp);
        tick(2);
        check("trigger count", trg_cnt - base, exp);
        base = trg_cnt;
    endtask : trg_is
    task automatic settle(input int n);
        tick(n);
        base = trg_cnt;
    endtask : settle
    task automatic pulse(input int ch, input logic [1:0] act, input logic [1:0] idle, input int n);
        volt[2*ch-2 +: 2] <= act;
        tick(n);
        volt[2*ch-2 +: 2] <= idle;
        tick(12);
    endtask : pulse
    task automatic fire(input logic two, input int k);
        if (two) ef2 <= 9'h001 << k;
        else ef1 <= 9'h001 << k;
        tick(1);
        ef1 <= 9'h000;
        ef2 <= 9'h000;
        tick(3);
    endtask : fire
    function automatic prt_pkg::prt_set_cfg_s mk(input logic wp, wt, tp, input logic [2:0] ws,
                                                input logic [28:0] lim, input logic rp, rq, input logic [2:0] rs);
        mk = '{wp, wt, tp, ws, lim, rp, rq, rs, 29'h1};
    endfunction : mk
    task automatic end_of_test;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_of_test
    initial begin
        tick(20000);
        miscompares++;
        end_of_test();
    end
    initial begin
        tick(5);
        reset_n <= 1'b1;
        // narrower ignores the elapsed point request
        cfg1 <= mk(1'b1, 1'b0, 1'b1, 3'h1, 29'h3, 1'b1, 1'b0, 3'h4);
        settle(4);
        check("tp readback", tpr, 2'h0);
        pulse(1, 2'h1, 2'h0, 2);
        trg_is(1);
        pulse(1, 2'h1, 2'h0, 3);
        trg_is(0);
        cfg1 <= mk(1'b1, 1'b1, 1'b0, 3'h3, 29'h3, 1'b1, 1'b0, 3'h4);
        settle(3);
        pulse(1, 2'h1, 2'h0, 6);
        trg_is(0);
        pulse(3, 2'h1, 2'h0, 3);
        trg_is(0);
        pulse(3, 2'h1, 2'h0, 4);
        trg_is(1);
        cfg1 <= mk(1'b1, 1'b1, 1'b1, 3'h3, 29'h3, 1'b1, 1'b0, 3'h4);
        settle(3);
        check("tp readback", tpr, 2'h1);
        volt[5:4] <= 2'h1;
        tick(10);
        trg_is(1);
        volt[5:4] <= 2'h0;
        tick(10);
        trg_is(0);
        // a zero limit clamps to one cycle, so a one-cycle pulse is not wider
        cfg1 <= mk(1'b1, 1'b1, 1'b0, 3'h3, 29'h0, 1'b1, 1'b0, 3'h4);
        settle(3);
        pulse(3, 2'h1, 2'h0, 1);
        trg_is(0);
        pulse(3, 2'h1, 2'h0, 2);
        trg_is(1);
        $display("test width done");
        cfg1 <= mk(1'b0, 1'b0, 1'b0, 3'h2, 29'h3, 1'b1, 1'b0, 3'h4);
        volt[3:2] <= 2'h1;
        settle(12);
        pulse(2, 2'h0, 2'h1, 2);
        trg_is(1);
        pulse(2, 2'h0, 2'h1, 3);
        trg_is(0);
        cfg1 <= mk(1'b0, 1'b1, 1'b1, 3'h0, 29'h3, 1'b1, 1'b0, 3'h4);
        settle(3);
        pulse(1, 2'h1, 2'h0, 2);
        trg_is(0);
        $display("test polarity and source done");
        ft <= prt_pkg::TERM_RUNT;
        cfg1 <= mk(1'b1, 1'b0, 1'b0, 3'h1, 29'h3, 1'b1, 1'b0, 3'h4);
        settle(3);
        pulse(4, 2'h1, 2'h0, 3);
        trg_is(1);
        pulse(4, 2'h2, 2'h0, 3);
        trg_is(0);
        cfg1 <= mk(1'b1, 1'b0, 1'b0, 3'h1, 29'h3, 1'b0, 1'b0, 3'h4);
        volt[7:6] <= 2'h2;
        settle(12);
        pulse(4, 2'h1, 2'h2, 3);
        trg_is(1);
        pulse(4, 2'h0, 2'h2, 3);
        trg_is(0);
        cfg1 <= mk(1'b1, 1'b0, 1'b0, 3'h1, 29'h3, 1'b1, 1'b1, 3'h4);
        volt[7:6] <= 2'h0;
        settle(12);
        check("runt readback", rqr, 2'h1);
        pulse(4, 2'h1, 2'h0, 1);
        trg_is(0);
        pulse(4, 2'h1, 2'h0, 2);
        trg_is(1);
        $display("test runt done");
        for (int k = 0; k < 9; k++) begin
            if (k == 2 || k == 3) continue;
            ft <= prt_pkg::prt_term_e'(9'h001 << k);
            settle(2);
            fire(1'b0, (k + 1) % 9);
            trg_is(0);
            fire(1'b0, k);
            trg_is(1);
        end
        seq_en <= 1'b1;
        ft <= prt_pkg::TERM_EDGE;
        for (int k = 0; k < 9; k++) begin
            if (k == 2 || k == 3) continue;
            st <= prt_pkg::prt_term_e'(9'h001 << k);
            settle(2);
            fire(1'b1, k);
            trg_is(0);
            fire(1'b0, 0);
            check("armed", armed, 1'b1);
            fire(1'b1, k);
            trg_is(1);
        end
        $display("test terms done");
        st <= prt_pkg::TERM_GLITCH;
        rte <= 1'b1;
        settle(2);
        fire(1'b0, 0);
        tick(6);
        check("armed", armed, 1'b0);
        fire(1'b1, 1);
        trg_is(0);
        rte <= 1'b0;
        de <= 1'b1;
        fire(1'b0, 0);
        fire(1'b1, 1);
        trg_is(0);
        tick(6);
        fire(1'b1, 1);
        trg_is(1);
        de <= 1'b0;
        $display("test reset and delay done");
        ft <= prt_pkg::TERM_WIDTH;
        st <= prt_pkg::TERM_RUNT;
        cfg1 <= mk(1'b1, 1'b0, 1'b0, 3'h1, 29'h3, 1'b1, 1'b0, 3'h1);
        cfg2 <= mk(1'b1, 1'b0, 1'b0, 3'h1, 29'h3, 1'b1, 1'b0, 3'h2);
        settle(3);
        pulse(2, 2'h1, 2'h0, 3);
        trg_is(0);
        pulse(1, 2'h1, 2'h0, 2);
        check("armed", armed, 1'b1);
        pulse(2, 2'h1, 2'h0, 3);
        trg_is(1);
        st <= prt_pkg::TERM_WIDTH;
        tick(3);
        check("long grant", ltg, 2'h1);
        cfg1 <= mk(1'b1, 1'b0, 1'b0, 3'h1, 29'h1, 1'b1, 1'b0, 3'h1);
        tick(3);
        check("long grant", ltg, 2'h2);
        ft <= prt_pkg::TERM_STATE;
        st <= prt_pkg::TERM_STATE;
        rr1 <= 1'b1;
        rr2 <= 1'b1;
        tick(3);
        check("range grant", rg, 2'h1);
        rr1 <= 1'b0;
        tick(3);
        check("range grant", rg, 2'h2);
        ft <= prt_pkg::TERM_TIMEOUT;
        st <= prt_pkg::TERM_TIMEOUT;
        elr1 <= 1'b1;
        elr2 <= 1'b1;
        tick(3);
        check("long grant", ltg, 2'h1);
        $display("test sequence and resources done");
        end_of_test();
    end
endmodule : tb_prt_trigger
`default_nettype wire
